// ===== swd_pkg.sv
// constants for the serial word decoder and its calibration sequencer
// assumes a 20 MHz system clock and an AHB-Lite register port
package swd_pkg;
   localparam int CLK_NS         = 50;
   localparam int STAGE_LONG_NS  = 650;
   localparam int STAGE_LAST_NS  = 350;
   localparam int SHORT_BUSY_NS  = 270;
   localparam int INIT_US        = 600;
   // longest times round down, never below one cycle
   localparam int STAGE_LONG_CYC = (STAGE_LONG_NS / CLK_NS) < 1 ? 1 : (STAGE_LONG_NS / CLK_NS);
   localparam int STAGE_LAST_CYC = (STAGE_LAST_NS / CLK_NS) < 1 ? 1 : (STAGE_LAST_NS / CLK_NS);
   localparam int SHORT_CYC      = (SHORT_BUSY_NS / CLK_NS) < 1 ? 1 : (SHORT_BUSY_NS / CLK_NS);
   localparam int INIT_CYC_DEF   = (INIT_US * 1000) / CLK_NS;

   // serial word layout
   localparam int WORD_BITS      = 29;
   localparam int RDWR_BIT       = 28;
   localparam int CHSEL_HI       = 27;
   localparam int CHSEL_LO       = 24;
   localparam int SETSEL_HI      = 23;
   localparam int SETSEL_LO      = 22;
   localparam int DATA_BITS      = 22;
   localparam int NUM_CH         = 4;

   // channel register fields
   localparam int CHANNEL_ENABLE_BIT_POS       = 21;
   localparam int FMODE_HI       = 20;
   localparam int FMODE_LO       = 19;
   localparam int CRANGE_HI      = 17;
   localparam int CRANGE_LO      = 15;
   localparam int CMPVI_POS      = 7;

   // force mode encodings
   localparam logic [1:0] FM_FV  = 2'h0;
   localparam logic [1:0] FM_FI  = 2'h1;
   localparam logic [1:0] FM_HZV = 2'h2;
   localparam logic [1:0] FM_HZI = 2'h3;

   typedef enum logic [1:0] {SET_CTRL, SET_GAIN, SET_OFFS, SET_INPUT} swd_set_t;

   // reset values
   localparam logic [15:0] GAIN_RST  = 16'hFFFF;
   localparam logic [15:0] OFFS_RST  = 16'h8000;
   localparam logic [15:0] INPUT_RST = 16'h0000;
   localparam logic [16:0] MID_CODE  = 17'h08000;

   // register map, byte addresses
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_LAST   = 8'h08;
   localparam logic [7:0] ADDR_SYSCTL = 8'h0C;
   localparam logic [7:0] ADDR_X2_0   = 8'h10;
   localparam int CTRL_LOAD_POS  = 0;
   localparam int CTRL_HOLD_POS  = 1;
endpackage

// ===== swd_cal_engine.sv
// shared calibration sequencer: stage one per channel in turn, then stages two and three
// assumes a single synchronous start pulse with a non-zero channel mask
`timescale 1ns/100ps
`default_nettype none
module swd_cal_engine #(
   parameter int ST_LONG = swd_pkg::STAGE_LONG_CYC,
   parameter int ST_LAST = swd_pkg::STAGE_LAST_CYC
) (
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       start_in,
   input  wire logic [3:0] mask_in,
   output logic            busy_out,
   output logic            stb_out,
   output logic [1:0]      ch_out
);
   import swd_pkg::*;
   typedef enum logic [1:0] {EN_IDLE, EN_ST1, EN_ST2, EN_ST3} swd_eng_t;

   swd_eng_t    state_q;
   logic [3:0]  rem_q;
   logic [1:0]  cur_q;
   logic [7:0]  cnt_q;
   logic [3:0]  rem_left;

   function automatic logic [1:0] first_ch(input logic [3:0] m);
      logic [1:0] r;
      r = 2'h0;
      for (int i = 3; i >= 0; i--) begin
         if (m[i]) r = 2'(i);
      end
      return r;
   endfunction

   assign rem_left = rem_q & ~(4'h1 << cur_q);

   // ==========================================
   // stage sequencing
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q <= EN_IDLE;
         rem_q   <= 4'h0;
         cur_q   <= 2'h0;
         cnt_q   <= 8'h00;
         stb_out <= 1'b0;
      end else begin
         stb_out <= 1'b0;
         if (start_in) begin
            state_q <= EN_ST1;
            rem_q   <= mask_in;
            cur_q   <= first_ch(mask_in);
            // start cycle is already the first cycle of stage one
            cnt_q   <= (ST_LONG > 1) ? 8'(ST_LONG - 2) : 8'h00;
         end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
         end else begin
            case (state_q)
               EN_ST1: begin
                  stb_out <= 1'b1;
                  rem_q   <= rem_left;
                  cnt_q   <= 8'(ST_LONG - 1);
                  if (rem_left != 4'h0) begin
                     cur_q <= first_ch(rem_left);
                  end else begin
                     state_q <= EN_ST2;
                  end
               end
               EN_ST2: begin
                  state_q <= EN_ST3;
                  cnt_q   <= 8'(ST_LAST - 1);
               end
               EN_ST3: state_q <= EN_IDLE;
               default: state_q <= EN_IDLE;
            endcase
         end
      end
   end

   assign busy_out = (state_q != EN_IDLE);
   assign ch_out   = cur_q;
endmodule
`default_nettype wire

// ===== swd_serial_decode.sv
// serial command word decoder with busy generation and load handling
// assumes pins arrive unsynchronised; registers are reached over AHB-Lite
// ==========================================
//
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module swd_serial_decode #(
   parameter int INIT_CYC = swd_pkg::INIT_CYC_DEF
) (
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   output logic [31:0]      hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   input  wire logic        sclk_in,
   input  wire logic        sdi_in,
   input  wire logic        sync_n_in,
   input  wire logic        load_n_in,
   input  wire logic        reset_pin_n_in,
   input  wire logic        busy_n_in,
   output logic             busy_n_out,
   output logic             busy_oe_out,
   output logic             update_out,
   output logic [3:0]       chan_enable_out
);
   import swd_pkg::*;

   // ==========================================
   // pin synchronisers
   localparam int NPIN = 6;
   logic [NPIN-1:0] pin_s1_q, pin_s2_q, pin_s3_q;
   logic sclk_fall, sync_fall, sync_rise, load_fall, rpin_fall;
   logic sdi_s, sync_s, load_s, rpin_s, bus_busy_n_s;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_s1_q <= '1;
         pin_s2_q <= '1;
         pin_s3_q <= '1;
      end else begin
         pin_s1_q <= {busy_n_in, reset_pin_n_in, load_n_in, sync_n_in, sdi_in, sclk_in};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   assign sdi_s        = pin_s2_q[1];
   assign sync_s       = pin_s2_q[2];
   assign load_s       = pin_s2_q[3];
   assign rpin_s       = pin_s2_q[4];
   assign bus_busy_n_s = pin_s2_q[5];
   assign sclk_fall    = pin_s3_q[0] & ~pin_s2_q[0];
   assign sync_fall    = pin_s3_q[2] & ~pin_s2_q[2];
   assign sync_rise    = ~pin_s3_q[2] & pin_s2_q[2];
   assign load_fall    = pin_s3_q[3] & ~pin_s2_q[3];
   assign rpin_fall    = pin_s3_q[4] & ~pin_s2_q[4];

   // ==========================================
   // initialisation after power-on or reset pin
   logic [31:0] init_cnt_q;
   logic        init_act;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         init_cnt_q <= 32'(INIT_CYC);
      end else if (rpin_fall || !rpin_s) begin
         init_cnt_q <= 32'(INIT_CYC);
      end else if (init_cnt_q != 32'h0) begin
         init_cnt_q <= init_cnt_q - 32'h1;
      end
   end
   assign init_act = (init_cnt_q != 32'h0);

   // ==========================================
   // serial shift register
   logic [WORD_BITS-1:0] shift_q;
   logic [5:0]           bits_q;
   logic                 hold_q;
   logic                 frame_done;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         shift_q <= '0;
         bits_q  <= 6'h00;
      end else if (sync_fall) begin
         bits_q <= 6'h00;
      end else if (!sync_s && sclk_fall) begin
         shift_q <= {shift_q[WORD_BITS-2:0], sdi_s};
         if (bits_q != 6'h3F) bits_q <= bits_q + 6'h01;
      end
   end
   assign frame_done = sync_rise && (bits_q >= 6'(WORD_BITS)) && !init_act && !hold_q;

   // ==========================================
   // header decode
   logic                 is_read;
   logic [3:0]           chsel;
   swd_set_t             set_sel;
   logic [DATA_BITS-1:0] wdata;
   logic                 is_nop;

   assign is_read = shift_q[RDWR_BIT];
   assign chsel   = shift_q[CHSEL_HI:CHSEL_LO];
   assign set_sel = swd_set_t'(shift_q[SETSEL_HI:SETSEL_LO]);
   assign wdata   = shift_q[DATA_BITS-1:0];
   assign is_nop  = (chsel == 4'h0) && (set_sel == SET_INPUT) && (&wdata);

   function automatic logic fm_short(input logic [1:0] o, input logic [1:0] n);
      return (o == n) || (o == FM_HZI && n == FM_FI) || (o == FM_FI && n == FM_HZI)
          || (o == FM_FV && n == FM_HZV) || (o == FM_HZV && n == FM_FV);
   endfunction

   function automatic logic needs_cal(input logic [DATA_BITS-1:0] o, input logic [DATA_BITS-1:0] n);
      return (o[CRANGE_HI:CRANGE_LO] != n[CRANGE_HI:CRANGE_LO])
          || (o[CMPVI_POS] != n[CMPVI_POS])
          || !fm_short(o[FMODE_HI:FMODE_LO], n[FMODE_HI:FMODE_LO]);
   endfunction

   function automatic logic [15:0] correct(input logic [15:0] x, input logic [15:0] m,
                                           input logic [15:0] c);
      logic [33:0] p;
      logic [17:0] s;
      p = {18'h0, x} * {17'h0, {1'b0, m} + 17'h1};
      s = {1'b0, p[32:16]} + {2'h0, c} - {1'b0, MID_CODE};
      if (s[17]) return 16'h0000;
      if (s[16]) return 16'hFFFF;
      return s[15:0];
   endfunction

   // ==========================================
   // channel and dac storage
   logic [DATA_BITS-1:0] ch_shadow_q [NUM_CH];
   logic [DATA_BITS-1:0] ch_active_q [NUM_CH];
   logic [15:0]          gain_q      [NUM_CH];
   logic [15:0]          offs_q      [NUM_CH];
   logic [15:0]          input_q     [NUM_CH];
   logic [15:0]          cached_q    [NUM_CH];
   logic [15:0]          dac_out_q   [NUM_CH];
   logic [DATA_BITS-1:0] sysctl_q;
   logic [WORD_BITS-1:0] last_q;
   logic [3:0]           long_mask;
   logic                 eng_stb;
   logic [1:0]           eng_ch;
   logic                 apply;

   always_comb begin
      long_mask = 4'h0;
      for (int i = 0; i < NUM_CH; i++) begin
         if (chsel[i] && !is_read) begin
            if (set_sel == SET_INPUT) long_mask[i] = 1'b1;
            if (set_sel == SET_CTRL && needs_cal(ch_shadow_q[i], wdata))
               long_mask[i] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < NUM_CH; i++) begin
            ch_shadow_q[i] <= '0;
            gain_q[i]      <= GAIN_RST;
            offs_q[i]      <= OFFS_RST;
            input_q[i]     <= INPUT_RST;
         end
         sysctl_q <= '0;
         last_q   <= '0;
      end else if (init_act) begin
         for (int i = 0; i < NUM_CH; i++) begin
            ch_shadow_q[i] <= '0;
            gain_q[i]      <= GAIN_RST;
            offs_q[i]      <= OFFS_RST;
            input_q[i]     <= INPUT_RST;
         end
         sysctl_q <= '0;
      end else if (frame_done) begin
         last_q <= shift_q;
         if (!is_read && chsel == 4'h0 && set_sel == SET_CTRL) begin
            sysctl_q <= wdata;
         end
         for (int i = 0; i < NUM_CH; i++) begin
            if (!is_read && chsel[i]) begin
               case (set_sel)
                  SET_CTRL:  ch_shadow_q[i] <= wdata;
                  SET_GAIN:  gain_q[i]      <= wdata[15:0];
                  SET_OFFS:  offs_q[i]      <= wdata[15:0];
                  SET_INPUT: input_q[i]     <= wdata[15:0];
                  default:   ch_shadow_q[i] <= ch_shadow_q[i];
               endcase
            end
         end
      end
   end

   // cached words are written as each first stage ends, for the next channel left in the mask, or for the same channel when none is left
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < NUM_CH; i++) cached_q[i] <= 16'h0000;
      end else if (eng_stb) begin
         cached_q[eng_ch] <= correct(input_q[eng_ch], gain_q[eng_ch], offs_q[eng_ch]);
      end
   end

   // ==========================================
   // busy generation
   logic [7:0] short_q;
   logic       eng_busy;
   logic       eng_start;
   logic       busy_int, busy_int_q;
   logic       short_start;

   assign eng_start   = frame_done && (long_mask != 4'h0);
   assign short_start = frame_done && long_mask == 4'h0 && !(is_nop && !is_read);

   swd_cal_engine #(
      .ST_LONG (STAGE_LONG_CYC),
      .ST_LAST (STAGE_LAST_CYC)
   ) u_engine (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .start_in (eng_start),
      .mask_in  (long_mask),
      .busy_out (eng_busy),
      .stb_out  (eng_stb),
      .ch_out   (eng_ch)
   );

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         short_q <= 8'h00;
      end else if (short_start) begin
         // the start cycle itself is the first short busy cycle
         short_q <= 8'(SHORT_CYC - 1);
      end else if (short_q != 8'h00) begin
         short_q <= short_q - 8'h01;
      end
   end

   assign busy_int = init_act || eng_busy || (short_q != 8'h00) || eng_start || short_start;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         busy_n_out  <= 1'b0;
         busy_oe_out <= 1'b1;
         busy_int_q  <= 1'b1;
      end else begin
         busy_n_out  <= 1'b0;
         busy_oe_out <= busy_int;
         busy_int_q  <= busy_int;
      end
   end

   // ==========================================
   // load handling
   logic load_pend_q;
   logic sw_load;
   logic busy_end;

   assign busy_end = busy_int_q && !busy_int;
   assign apply    = load_pend_q && !busy_int && bus_busy_n_s && !busy_oe_out;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         load_pend_q <= 1'b0;
      end else if (init_act) begin
         load_pend_q <= 1'b0;
      end else if (load_fall || sw_load || (busy_end && !load_s)) begin
         load_pend_q <= 1'b1;
      end else if (apply) begin
         load_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         update_out      <= 1'b0;
         chan_enable_out <= 4'h0;
         for (int i = 0; i < NUM_CH; i++) begin
            ch_active_q[i] <= '0;
            dac_out_q[i]   <= 16'h0000;
         end
      end else begin
         update_out <= apply;
         if (apply) begin
            for (int i = 0; i < NUM_CH; i++) begin
               ch_active_q[i]     <= ch_shadow_q[i];
               dac_out_q[i]       <= cached_q[i];
               chan_enable_out[i] <= ch_shadow_q[i][CHANNEL_ENABLE_BIT_POS];
            end
         end
      end
   end

   // ==========================================
   // AHB-Lite register port
   logic       wr_pend_q;
   logic [7:0] wr_addr_q;
   logic       addr_ok;
   logic [7:0] a_addr;
   logic [31:0] rd_mux;

   assign a_addr  = haddr_in[7:0];
   assign addr_ok = hsel_in && htrans_in[1] && hready_in;

   always_comb begin
      rd_mux = 32'h0;
      case (a_addr)
         ADDR_CTRL:   rd_mux = {30'h0, hold_q, 1'b0};
         ADDR_STATUS: rd_mux = {27'h0, init_act, eng_busy, load_pend_q, bus_busy_n_s, busy_int};
         ADDR_LAST:   rd_mux = {3'h0, last_q};
         ADDR_SYSCTL: rd_mux = {10'h0, sysctl_q};
         default: begin
            for (int i = 0; i < NUM_CH; i++) begin
               if (a_addr == ADDR_X2_0 + 8'(4 * i))
                  rd_mux = {dac_out_q[i], cached_q[i]};
            end
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_pend_q     <= 1'b0;
         wr_addr_q     <= 8'h00;
         hrdata_out    <= 32'h0;
         hreadyout_out <= 1'b1;
         hresp_out     <= 1'b0;
      end else begin
         hreadyout_out <= 1'b1;
         hresp_out     <= 1'b0;
         wr_pend_q     <= addr_ok && hwrite_in;
         if (addr_ok) wr_addr_q <= a_addr;
         if (addr_ok && !hwrite_in) hrdata_out <= rd_mux;
      end
   end

   assign sw_load = wr_pend_q && (wr_addr_q == ADDR_CTRL) && hwdata_in[CTRL_LOAD_POS];

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hold_q <= 1'b0;
      end else if (wr_pend_q && wr_addr_q == ADDR_CTRL) begin
         hold_q <= hwdata_in[CTRL_HOLD_POS];
      end
   end
endmodule
`default_nettype wire

// ===== swd_checker.sv
// port checker for the serial word decoder
// assumes the bench binds it to the decoder top
`timescale 1ns/100ps
`default_nettype none
module swd_checker #(
   parameter int INIT_CYC = 20
) (
   input wire logic        clk_in,
   input wire logic        rst_n_in,
   input wire logic        hsel_in,
   input wire logic [1:0]  htrans_in,
   input wire logic        hwrite_in,
   input wire logic        hready_in,
   input wire logic [31:0] hrdata_out,
   input wire logic        hreadyout_out,
   input wire logic        hresp_out,
   input wire logic        sync_n_in,
   input wire logic        reset_pin_n_in,
   input wire logic        busy_n_out,
   input wire logic        busy_oe_out,
   input wire logic        update_out,
   input wire logic [3:0]  chan_enable_out
);
   // longest write busy is five long stages plus the last one
   localparam int LIM = (INIT_CYC > 70) ? INIT_CYC + 4 : 74;
   logic [8:0] run_q;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // ==========
   // length of the present busy stretch
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         run_q <= 9'h000;
      end else if (!busy_oe_out || !reset_pin_n_in) begin
         run_q <= 9'h000;
      end else if (run_q != 9'h1FF) begin
         run_q <= run_q + 9'h001;
      end
   end
   // ==========
   // properties
   property p_init_busy;
      $rose(rst_n_in) |-> busy_oe_out [*8];
   endproperty
   a_init_busy: assert property (p_init_busy) else $error("busy not held after reset");
   property p_pin_reset;
      $fell(reset_pin_n_in) |-> ##[1:4] busy_oe_out [*3];
   endproperty
   a_pin_reset: assert property (p_pin_reset) else $error("busy not driven on reset pin fall");
   property p_bus_ok;
      hreadyout_out && !hresp_out && !busy_n_out;
   endproperty
   a_bus_ok: assert property (p_bus_ok) else $error("bus response or busy drive level wrong");
   property p_busy_max;
      run_q <= LIM;
   endproperty
   a_busy_max: assert property (p_busy_max) else $error("busy stretch too long");
   property p_busy_cause;
      $rose(busy_oe_out) && reset_pin_n_in |-> sync_n_in && !$past(sync_n_in, 8);
   endproperty
   a_busy_cause: assert property (p_busy_cause) else $error("busy rose without frame end");
   property p_load_gate;
      update_out |-> !$past(busy_oe_out);
   endproperty
   a_load_gate: assert property (p_load_gate) else $error("update while busy driven");
   property p_update_pulse;
      update_out |=> !update_out;
   endproperty
   a_update_pulse: assert property (p_update_pulse) else $error("update longer than a cycle");
   property p_channel_enable_bit_on_load;
      $changed(chan_enable_out) && reset_pin_n_in |-> update_out;
   endproperty
   a_channel_enable_bit_on_load: assert property (p_channel_enable_bit_on_load) else $error("channel enable moved without load");
   property p_rdata_hold;
      !(hsel_in && htrans_in[1] && !hwrite_in && hready_in) |=> $stable(hrdata_out);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
endmodule
`default_nettype wire

// ===== swd_host_model.sv
// host controller model: frames serial command words
// assumes the busy line reads high when nobody pulls it
`timescale 1ns/100ps
`default_nettype none
module swd_host_model (
   input  wire logic busy_n_in,
   output logic      sclk_out,
   output logic      sdi_out,
   output logic      sync_n_out
);
   initial begin
      sclk_out = 1'b1;
      sdi_out = 1'b0;
      sync_n_out = 1'b1;
   end
   // ==========
   // one frame of the top nb bits; clock idles high between frames
   task automatic send(input logic [28:0] w, input int nb);
      wait (busy_n_in === 1'b1);
      #113;
      sync_n_out = 1'b0;
      for (int i = 0; i < nb; i++) begin
         #100;
         sdi_out = w[28 - i];
         #100;
         sclk_out = 1'b0;
         #200;
         sclk_out = 1'b1;
      end
      #100;
      sync_n_out = 1'b1;
      sdi_out = ~sdi_out;
   endtask
endmodule
`default_nettype wire

// ===== test_serial_word_decode_cal_busy.sv
// bench for the serial word decoder: bus, frames, busy and load
// assumes the host model and the checker beside it
`timescale 1ns/100ps
`default_nettype none
module test_serial_word_decode_cal_busy;
   import swd_pkg::*;
   localparam int SB = SHORT_CYC;
   logic        clk_in = 0, rst_n_in = 0, hsel_in = 0, hwrite_in = 0;
   logic        load_n_in = 1, reset_pin_n_in = 1;
   logic [1:0]  htrans_in = 0;
   logic [2:0]  hsize_in = 3'h2;
   logic [31:0] haddr_in = 0, hwdata_in = 0, hrdata_out, rd;
   logic [3:0]  chan_enable_out;
   logic        hreadyout_out, hresp_out, busy_n_out, busy_oe_out, update_out;
   logic        sclk_in, sdi_in, sync_n_in;
   wire         hready_in = hreadyout_out;
   wire         busy_n_in = busy_oe_out ? busy_n_out : 1'b1;
   int          err_total = 0, total_checks = 0, n;
   logic [28:0] w [13];
   int          e [13];
   swd_serial_decode #(.INIT_CYC(20)) dut_u (.clk_in, .rst_n_in, .hsel_in, .haddr_in, .htrans_in,
      .hwrite_in, .hsize_in, .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out,
      .sclk_in, .sdi_in, .sync_n_in, .load_n_in, .reset_pin_n_in, .busy_n_in, .busy_n_out,
      .busy_oe_out, .update_out, .chan_enable_out);
   swd_host_model host_u (.busy_n_in(busy_n_in), .sclk_out(sclk_in), .sdi_out(sdi_in), .sync_n_out(sync_n_in));
   always #25 clk_in = ~clk_in;
   // ==========
   // shared tasks
   function automatic int lb(int k);
      return (k + 1) * STAGE_LONG_CYC + STAGE_LAST_CYC;
   endfunction
   task automatic tick();
      @(posedge clk_in);
      #1;
   endtask
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      total_checks++;
      if (got !== ex) begin
         err_total++;
         $display("[FAIL] %s expected %0h seen %0h", nm, ex, got);
      end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
      tick();
      hsel_in <= 1'b1;
      htrans_in <= 2'h2;
      hwrite_in <= wr;
      haddr_in <= {24'h0, a};
      tick();
      while (hready_in !== 1'b1) tick();
      hsel_in <= 1'b0;
      htrans_in <= 2'h0;
      hwdata_in <= wd;
      tick();
      while (hready_in !== 1'b1) tick();
      d = hrdata_out;
   endtask
   task automatic measure(output int k);
      k = 0;
      for (int i = 0; i < 16 && busy_oe_out !== 1'b1; i++) tick();
      while (busy_oe_out === 1'b1 && k < 300) begin
         tick();
         k++;
      end
   endtask
   task automatic wait_upd();
      for (int i = 0; i < 300 && update_out !== 1'b1; i++) tick();
      chk("update", 1, update_out);
      chk("busy at update", 0, busy_oe_out);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ==========
   // tests
   initial begin
      w[0] = {1'b0, 4'h0, 2'h0, 22'h000001}; e[0] = SB;
      w[1] = {1'b1, 4'h0, 2'h0, 22'h000000}; e[1] = SB;
      w[2] = {1'b0, 4'h1, 2'h1, 22'h00FFFF}; e[2] = SB;
      w[3] = {1'b0, 4'h1, 2'h2, 22'h008000}; e[3] = SB;
      w[4] = {1'b0, 4'h1, 2'h3, 22'h001234}; e[4] = lb(1);
      w[5] = {1'b0, 4'hF, 2'h3, 22'h004321}; e[5] = lb(4);
      w[6] = {1'b0, 4'h1, 2'h0, 22'h200000}; e[6] = SB;
      w[7] = {1'b0, 4'h1, 2'h0, 22'h300000}; e[7] = SB;
      w[8] = {1'b0, 4'h1, 2'h0, 22'h380000}; e[8] = lb(1);
      w[9] = {1'b0, 4'h1, 2'h0, 22'h288000}; e[9] = lb(1);
      w[10] = {1'b0, 4'h1, 2'h0, 22'h28A080}; e[10] = lb(1);
      w[11] = {1'b0, 4'h1, 2'h0, 22'h28BFC0}; e[11] = SB;
      w[12] = {1'b0, 4'h3, 2'h0, 22'h210080}; e[12] = lb(2);
      repeat (8) @(posedge clk_in);
      rst_n_in <= 1'b1;
      tick();
      chk("init busy", 1, busy_oe_out);
      measure(n);
      ahb(1'b0, 8'h40, 32'h0, rd);
      chk("unmapped", 0, rd);
      $display("test reset done");
      for (int i = 0; i < 13; i++) begin
         host_u.send(w[i], 29);
         measure(n);
         chk("busy length", e[i], n);
         ahb(1'b0, ADDR_LAST, 32'h0, rd);
         chk("last word", {3'h0, w[i]}, rd);
      end
      $display("test busy table done");
      host_u.send(w[4], 20);
      measure(n);
      chk("short frame", 0, n);
      host_u.send({1'b0, 4'h0, 2'h3, 22'h3FFFFF}, 29);
      measure(n);
      chk("nop", 0, n);
      ahb(1'b1, ADDR_CTRL, 32'h2, rd);
      ahb(1'b0, ADDR_CTRL, 32'h0, rd);
      chk("hold", 2, rd);
      host_u.send(w[4], 29);
      measure(n);
      chk("held frame", 0, n);
      ahb(1'b1, ADDR_CTRL, 32'h0, rd);
      $display("test refusals done");
      host_u.send(w[5], 29);
      repeat (10) tick();
      load_n_in <= 1'b0;
      tick();
      tick();
      load_n_in <= 1'b1;
      wait_upd();
      chk("channel enable", 4'h3, chan_enable_out);
      ahb(1'b0, ADDR_X2_0 + 8'h04, 32'h0, rd);
      chk("cached word", 32'h43214321, rd);
      ahb(1'b1, ADDR_CTRL, 32'h1, rd);
      wait_upd();
      ahb(1'b0, ADDR_CTRL, 32'h0, rd);
      chk("ctrl readback", 0, rd);
      $display("test load done");
      reset_pin_n_in <= 1'b0;
      repeat (6) tick();
      chk("pin busy", 1, busy_oe_out);
      reset_pin_n_in <= 1'b1;
      repeat (5) tick();
      chk("pin init busy", 1, busy_oe_out);
      measure(n);
      $display("test reset pin done");
      conclude();
   end
   initial begin
      repeat (20000) @(posedge clk_in);
      err_total++;
      conclude();
   end
endmodule
bind swd_serial_decode swd_checker #(.INIT_CYC(INIT_CYC)) chk_u (.clk_in, .rst_n_in, .hsel_in, .htrans_in,
   .hwrite_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .sync_n_in, .reset_pin_n_in,
   .busy_n_out, .busy_oe_out, .update_out, .chan_enable_out);
`default_nettype wire
